// *** rtl/rps_defs.vh ***
// Register map, field positions, reset values and codes of the reduced power stage controller
`ifndef RPS_DEFS_VH
`define RPS_DEFS_VH
// Register addresses
`define RPS_ADDR_CTRL 4'h0
`define RPS_ADDR_SYNC_OUT 4'h1
`define RPS_ADDR_SET_A 4'h2
`define RPS_ADDR_RST_A 4'h3
`define RPS_ADDR_SET_B 4'h4
`define RPS_ADDR_RST_B 4'h5
`define RPS_ADDR_IN_SEL 4'h6
`define RPS_ADDR_CAPTURE 4'h7
`define RPS_ADDR_STATUS 4'h8
`define RPS_ADDR_COUNT 4'h9
// Control register fields
`define RPS_CTRL_RUN 0
`define RPS_CTRL_MODE_LO 1
`define RPS_CTRL_MODE_HI 2
`define RPS_CTRL_CLKSEL 3
// Sync and output configuration fields
`define RPS_SOC_POL 0
`define RPS_SOC_OUT_EN 1
// Input select fields
`define RPS_INSEL_A_LO 0
`define RPS_INSEL_A_HI 1
`define RPS_INSEL_B_LO 2
`define RPS_INSEL_B_HI 3
`define RPS_INSEL_A_EN 4
`define RPS_INSEL_B_EN 5
// Status fields, write one to clear
`define RPS_ST_OVF 0
`define RPS_ST_FAULT 1
`define RPS_ST_CAPT 2
// Extended fuse byte positions
`define RPS_FUSE_REDUCED 5
`define RPS_FUSE_LEVEL 4
`define RPS_FUSE_PULLUP 3
`define RPS_FUSE_DEFAULT 8'hff
// Running modes
`define RPS_MODE_FOUR 2'h0
`define RPS_MODE_TWO 2'h1
`define RPS_MODE_ONE 2'h2
`define RPS_MODE_CENTER 2'h3
// Least dead time in four-ramp mode, in counter periods
`define RPS_DEAD_EXTRA 12'h002
`endif

// *** rtl/rps_top.v ***
// Reduced power stage waveform controller with register port
//
// Overview of operation
// - Forced reset level follows drive-level fuse
// - Reduced fuse one leaves outputs as ports
// - Reduced fuse zero forces until config write
// - Pull-up fuse zero forces input pull-ups while reset is held
// - Pull-up fuse never touches alternate pin B
// - Fuse bits 5, 4, 3 default one
// - Software selects output polarity
// - Up/down counter between register limits
// - Part A drives out 0, part B out 1
// - Four 12-bit set/reset compare values
// - Counter clock from I/O or PLL
// - Four selectable retrigger/fault sources
// - Retrigger loads counter into capture register
// - One interrupt from overflow, fault, capture
// - Sync pulse to ADC and amplifier
// - Sub-cycle A then B; cycle ends after B
// - New values load at top of last ramp
// - Centered mode counts up then down
// - Four, two, one ramp modes, 12-bit times
// - Frequency is clock over times sum
// - Four-ramp on-times equal reset values
// - Four-ramp dead time is set plus two
// - Stopped updates immediate, running at cycle end (centered: at the top)
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
`include "rps_defs.vh"
module rps_top #(
    parameter WIDTH = 12
) (
    input wire ref_clk,
    input wire rst,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire [7:0] ext_fuse_byte,
    input wire pll_tick,
    input wire main_trigger_pin,
    input wire comparator_out,
    input wire alt_trigger_pin_a,
    input wire alt_trigger_pin_b,
    output reg wave_out_a,
    output reg wave_out_a_oe_n,
    output reg wave_out_b,
    output reg wave_out_b_oe_n,
    output reg main_pin_pullup,
    output reg alt_a_pullup,
    output reg alt_b_pullup,
    output reg controller_irq,
    output reg adc_sync_pulse
);
    // Phases of a cycle: dead/on of part A then dead/on of part B
    localparam PH_DEAD_A = 2'h0;
    localparam PH_ON_A = 2'h1;
    localparam PH_DEAD_B = 2'h2;
    localparam PH_ON_B = 2'h3;

    reg [WIDTH-1:0] set_a_q, rst_a_q, set_b_q, rst_b_q;
    reg [WIDTH-1:0] wset_a_q, wrst_a_q, wset_b_q, wrst_b_q;
    reg [WIDTH-1:0] cnt_q, capture_value;
    reg [1:0] phase_q, mode_q, wmode_q;
    reg run_q, clksel_q, pol_q, out_en_q, dir_down_q, pending_q, ramp_b_q;
    reg [1:0] sel_a_q, sel_b_q;
    reg trig_en_a_q, trig_en_b_q, trig_prev_a_q, trig_prev_b_q;
    reg [2:0] status_q, irq_mask_q;
    reg [7:0] fuse_q;
    reg forced_q;
    reg act_a, act_b, last_ramp, ramp_end, top, trig_a, trig_b;
    reg [WIDTH-1:0] limit;
    wire tick;
    wire in_a;
    wire in_b;

    // Pick one of the four retrigger/fault sources by index
    function pick_src;
        input [1:0] sel;
        input s0, s1, s2, s3;
        begin
            case (sel)
                2'h0: pick_src = s0;
                2'h1: pick_src = s1;
                2'h2: pick_src = s2;
                default: pick_src = s3;
            endcase
        end
    endfunction

    // Counter enable: every I/O clock or one PLL-derived tick
    assign tick = clksel_q ? pll_tick : 1'b1;
    // Each part has its own input selection
    assign in_a = pick_src(sel_a_q, main_trigger_pin, comparator_out,
                           alt_trigger_pin_a, alt_trigger_pin_b);
    assign in_b = pick_src(sel_b_q, main_trigger_pin, comparator_out,
                           alt_trigger_pin_a, alt_trigger_pin_b);

    // Phase length and ramp decode from the working values
    always @*
    begin
        trig_a = trig_en_a_q & in_a & ~trig_prev_a_q;
        trig_b = trig_en_b_q & in_b & ~trig_prev_b_q;
        act_a = 1'b0;
        act_b = 1'b0;
        limit = {WIDTH{1'b0}};
        top = 1'b0;
        case (mode_q)
            `RPS_MODE_FOUR:
            begin
                case (phase_q)
                    PH_DEAD_A: limit = wset_a_q + `RPS_DEAD_EXTRA - 1'b1;
                    PH_ON_A: limit = wrst_a_q - 1'b1;
                    PH_DEAD_B: limit = wset_b_q + `RPS_DEAD_EXTRA - 1'b1;
                    default: limit = wrst_b_q - 1'b1;
                endcase
                act_a = phase_q == PH_ON_A;
                act_b = phase_q == PH_ON_B;
                top = cnt_q == limit;
            end
            `RPS_MODE_TWO:
            begin
                limit = ramp_b_q ? wrst_b_q : wrst_a_q;
                act_a = ~ramp_b_q & (cnt_q > wset_a_q);
                act_b = ramp_b_q & (cnt_q > wset_b_q);
                top = cnt_q == limit;
            end
            default:
            begin
                // One ramp and centered share the single ramp; outputs may overlap
                limit = wrst_b_q;
                act_a = (cnt_q > wset_a_q) & (cnt_q <= wrst_a_q);
                act_b = (cnt_q > wset_b_q) & (cnt_q <= wrst_b_q);
                top = cnt_q == limit;
            end
        endcase
        // Four-, two- and one-ramp have their last ramp end at the top; centered turns back there
        last_ramp = (mode_q == `RPS_MODE_FOUR) ? (phase_q == PH_ON_B) :
                    (mode_q == `RPS_MODE_TWO) ? ramp_b_q : 1'b1;
        ramp_end = (mode_q == `RPS_MODE_CENTER) ? (dir_down_q & (cnt_q == {WIDTH{1'b0}})) : top;
    end

    // Fuses sampled while reset is held, then frozen
    always @(posedge ref_clk)
    begin
        if (rst)
            fuse_q <= ext_fuse_byte;
    end

    // Register writes and working-value transfer
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            run_q <= 1'b0;
            mode_q <= `RPS_MODE_FOUR;
            wmode_q <= `RPS_MODE_FOUR;
            clksel_q <= 1'b0;
            pol_q <= 1'b0;
            out_en_q <= 1'b0;
            set_a_q <= {WIDTH{1'b0}};
            rst_a_q <= {WIDTH{1'b0}};
            set_b_q <= {WIDTH{1'b0}};
            rst_b_q <= {WIDTH{1'b0}};
            wset_a_q <= {WIDTH{1'b0}};
            wrst_a_q <= {WIDTH{1'b0}};
            wset_b_q <= {WIDTH{1'b0}};
            wrst_b_q <= {WIDTH{1'b0}};
            sel_a_q <= 2'h0;
            sel_b_q <= 2'h0;
            trig_en_a_q <= 1'b0;
            trig_en_b_q <= 1'b0;
            irq_mask_q <= 3'h0;
            pending_q <= 1'b0;
            forced_q <= 1'b1;
        end
        else
        begin
            // A stopped controller takes new values at once
            if (!run_q)
            begin
                wset_a_q <= set_a_q;
                wrst_a_q <= rst_a_q;
                wset_b_q <= set_b_q;
                wrst_b_q <= rst_b_q;
                mode_q <= wmode_q;
                pending_q <= 1'b0;
            end
            else if (pending_q && tick && last_ramp && top)
            begin
                wset_a_q <= set_a_q;
                wrst_a_q <= rst_a_q;
                wset_b_q <= set_b_q;
                wrst_b_q <= rst_b_q;
                mode_q <= wmode_q;
                pending_q <= 1'b0;
            end
            if (reg_wr)
            begin
                case (reg_addr)
                    `RPS_ADDR_CTRL:
                    begin
                        run_q <= reg_wdata[`RPS_CTRL_RUN];
                        wmode_q <= reg_wdata[`RPS_CTRL_MODE_HI:`RPS_CTRL_MODE_LO];
                        clksel_q <= reg_wdata[`RPS_CTRL_CLKSEL];
                        irq_mask_q <= reg_wdata[6:4];
                        pending_q <= 1'b1;
                    end
                    `RPS_ADDR_SYNC_OUT:
                    begin
                        pol_q <= reg_wdata[`RPS_SOC_POL];
                        out_en_q <= reg_wdata[`RPS_SOC_OUT_EN];
                        forced_q <= 1'b0;
                    end
                    `RPS_ADDR_SET_A: set_a_q <= reg_wdata[WIDTH-1:0];
                    `RPS_ADDR_RST_A: rst_a_q <= reg_wdata[WIDTH-1:0];
                    `RPS_ADDR_SET_B: set_b_q <= reg_wdata[WIDTH-1:0];
                    `RPS_ADDR_RST_B: rst_b_q <= reg_wdata[WIDTH-1:0];
                    `RPS_ADDR_IN_SEL:
                    begin
                        sel_a_q <= reg_wdata[`RPS_INSEL_A_HI:`RPS_INSEL_A_LO];
                        sel_b_q <= reg_wdata[`RPS_INSEL_B_HI:`RPS_INSEL_B_LO];
                        trig_en_a_q <= reg_wdata[`RPS_INSEL_A_EN];
                        trig_en_b_q <= reg_wdata[`RPS_INSEL_B_EN];
                    end
                    default: ;
                endcase
                if (reg_addr >= `RPS_ADDR_SET_A && reg_addr <= `RPS_ADDR_RST_B)
                    pending_q <= 1'b1;
            end
        end
    end

    // Counter, phase sequencing, capture and event flags
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            cnt_q <= {WIDTH{1'b0}};
            capture_value <= {WIDTH{1'b0}};
            phase_q <= PH_DEAD_A;
            dir_down_q <= 1'b0;
            ramp_b_q <= 1'b0;
            status_q <= 3'h0;
            trig_prev_a_q <= 1'b0;
            trig_prev_b_q <= 1'b0;
            adc_sync_pulse <= 1'b0;
        end
        else
        begin
            trig_prev_a_q <= in_a;
            trig_prev_b_q <= in_b;
            adc_sync_pulse <= 1'b0;
            // Clear by writing one; a same-cycle event still sets
            if (reg_wr && reg_addr == `RPS_ADDR_STATUS)
                status_q <= status_q & ~reg_wdata[2:0];
            if (run_q && (trig_a || trig_b))
            begin
                capture_value <= cnt_q;
                status_q[`RPS_ST_CAPT] <= 1'b1;
                status_q[`RPS_ST_FAULT] <= 1'b1;
                // Retrigger ends the current sub-cycle early
                if (mode_q == `RPS_MODE_ONE || mode_q == `RPS_MODE_CENTER)
                begin
                    cnt_q <= {WIDTH{1'b0}};
                    dir_down_q <= 1'b0;
                end
                else
                begin
                    cnt_q <= {WIDTH{1'b0}};
                    phase_q <= trig_a ? PH_DEAD_B : PH_DEAD_A;
                    ramp_b_q <= trig_a;
                end
            end
            else if (run_q && tick)
            begin
                if (mode_q == `RPS_MODE_CENTER)
                begin
                    cnt_q <= dir_down_q ? cnt_q - 1'b1 : cnt_q + 1'b1;
                    if (top && !dir_down_q)
                    begin
                        dir_down_q <= 1'b1;
                        cnt_q <= cnt_q - 1'b1;
                        adc_sync_pulse <= 1'b1;
                    end
                    else if (ramp_end)
                    begin
                        dir_down_q <= 1'b0;
                        cnt_q <= cnt_q + 1'b1;
                        status_q[`RPS_ST_OVF] <= 1'b1;
                    end
                end
                else if (ramp_end)
                begin
                    cnt_q <= {WIDTH{1'b0}};
                    phase_q <= phase_q + 2'h1;
                    ramp_b_q <= ~ramp_b_q;
                    if (last_ramp)
                    begin
                        phase_q <= PH_DEAD_A;
                        ramp_b_q <= 1'b0;
                        status_q[`RPS_ST_OVF] <= 1'b1;
                        adc_sync_pulse <= 1'b1;
                    end
                end
                else
                    cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    // Output pins: forced level, port release, or polarity-adjusted wave
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            wave_out_a <= ext_fuse_byte[`RPS_FUSE_LEVEL];
            wave_out_b <= ext_fuse_byte[`RPS_FUSE_LEVEL];
            wave_out_a_oe_n <= ext_fuse_byte[`RPS_FUSE_REDUCED];
            wave_out_b_oe_n <= ext_fuse_byte[`RPS_FUSE_REDUCED];
            main_pin_pullup <= ~ext_fuse_byte[`RPS_FUSE_PULLUP];
            alt_a_pullup <= ~ext_fuse_byte[`RPS_FUSE_PULLUP];
            alt_b_pullup <= 1'b0;
            controller_irq <= 1'b0;
            reg_rdata <= 16'h0000;
        end
        else
        begin
            // Pull-ups are forced only while reset is held
            main_pin_pullup <= 1'b0;
            alt_a_pullup <= 1'b0;
            alt_b_pullup <= 1'b0;
            if (forced_q && !fuse_q[`RPS_FUSE_REDUCED])
            begin
                wave_out_a <= fuse_q[`RPS_FUSE_LEVEL];
                wave_out_b <= fuse_q[`RPS_FUSE_LEVEL];
                wave_out_a_oe_n <= 1'b0;
                wave_out_b_oe_n <= 1'b0;
            end
            else
            begin
                wave_out_a <= act_a ^ pol_q;
                wave_out_b <= act_b ^ pol_q;
                wave_out_a_oe_n <= ~out_en_q;
                wave_out_b_oe_n <= ~out_en_q;
            end
            controller_irq <= |(status_q & irq_mask_q);
            reg_rdata <= 16'h0000;
            if (reg_rd)
            begin
                case (reg_addr)
                    `RPS_ADDR_CTRL: reg_rdata <= {9'h000, irq_mask_q, clksel_q, wmode_q, run_q};
                    `RPS_ADDR_SYNC_OUT: reg_rdata <= {14'h0000, out_en_q, pol_q};
                    `RPS_ADDR_SET_A: reg_rdata <= {{(16-WIDTH){1'b0}}, set_a_q};
                    `RPS_ADDR_RST_A: reg_rdata <= {{(16-WIDTH){1'b0}}, rst_a_q};
                    `RPS_ADDR_SET_B: reg_rdata <= {{(16-WIDTH){1'b0}}, set_b_q};
                    `RPS_ADDR_RST_B: reg_rdata <= {{(16-WIDTH){1'b0}}, rst_b_q};
                    `RPS_ADDR_IN_SEL:
                        reg_rdata <= {10'h000, trig_en_b_q, trig_en_a_q, sel_b_q, sel_a_q};
                    `RPS_ADDR_CAPTURE: reg_rdata <= {{(16-WIDTH){1'b0}}, capture_value};
                    `RPS_ADDR_STATUS: reg_rdata <= {13'h0000, status_q};
                    `RPS_ADDR_COUNT: reg_rdata <= {{(16-WIDTH){1'b0}}, cnt_q};
                    default: reg_rdata <= 16'h0000;
                endcase
            end
        end
    end
endmodule // rps_top

// *** dv/rps_top_sva.sv ***
// Port-level assertions for the reduced power stage controller
`timescale 1ns/100ps
`include "rps_defs.vh"
module rps_top_sva (
    input wire ref_clk,
    input wire rst,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire [7:0] ext_fuse_byte,
    input wire wave_out_a,
    input wire wave_out_a_oe_n,
    input wire wave_out_b,
    input wire wave_out_b_oe_n,
    input wire main_pin_pullup,
    input wire alt_a_pullup,
    input wire alt_b_pullup,
    input wire adc_sync_pulse
);
    reg forced_q;
    // Forced phase starts in reset and ends with the first config write
    always @(posedge ref_clk)
    begin
        if (rst)
            forced_q <= !ext_fuse_byte[`RPS_FUSE_REDUCED];
        else if (reg_wr && reg_addr == `RPS_ADDR_SYNC_OUT)
            forced_q <= 1'b0;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // First edge after release still shows the levels taken under reset
    sequence s_release;
        !rst && $past(rst);
    endsequence
    sequence s_sync_wr(en);
        reg_wr && reg_addr == `RPS_ADDR_SYNC_OUT && reg_wdata[`RPS_SOC_OUT_EN] == en;
    endsequence
    a_forced_level: assert property (
        forced_q |-> !wave_out_a_oe_n && !wave_out_b_oe_n
        && wave_out_a == ext_fuse_byte[`RPS_FUSE_LEVEL]
        && wave_out_b == ext_fuse_byte[`RPS_FUSE_LEVEL])
        else $error("forced reset level not held");
    a_reduced_port: assert property (
        s_release and ext_fuse_byte[`RPS_FUSE_REDUCED] && !$past(reg_wr)
        |-> wave_out_a_oe_n && wave_out_b_oe_n)
        else $error("outputs driven with reduced fuse set");
    a_pullup_level: assert property (
        s_release |-> main_pin_pullup == !ext_fuse_byte[`RPS_FUSE_PULLUP]
        && alt_a_pullup == !ext_fuse_byte[`RPS_FUSE_PULLUP])
        else $error("reset pull-up level wrong");
    a_pullup_brief: assert property (
        s_release |=> !main_pin_pullup && !alt_a_pullup)
        else $error("pull-up kept after reset");
    a_alt_b_free: assert property (!alt_b_pullup)
        else $error("pull-up forced on pin B");
    a_release_port: assert property (
        s_sync_wr(1'b0) |=> ##1 wave_out_a_oe_n && wave_out_b_oe_n)
        else $error("outputs still driven after release");
    a_drive_en: assert property (
        s_sync_wr(1'b1) |=> ##1 !wave_out_a_oe_n && !wave_out_b_oe_n)
        else $error("outputs not driven after enable");
    a_sync_pulse: assert property (
        adc_sync_pulse |=> !adc_sync_pulse)
        else $error("sync pulse longer than a cycle");
endmodule // rps_top_sva

bind rps_top rps_top_sva u_rps_top_sva (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .ext_fuse_byte, .wave_out_a, .wave_out_a_oe_n, .wave_out_b, .wave_out_b_oe_n,
    .main_pin_pullup, .alt_a_pullup, .alt_b_pullup, .adc_sync_pulse);

// *** dv/rps_stage_model.sv ***
// Power stage model: measures gate pulses seen at the two waveform pins
`timescale 1ns/100ps
module rps_stage_model (
    input wire ref_clk,
    input wire wave_out_a,
    input wire wave_out_a_oe_n,
    input wire wave_out_b,
    input wire wave_out_b_oe_n,
    output reg [7:0] on_a,
    output reg [7:0] on_b,
    output reg [7:0] per_a
);
    reg [7:0] run_a_q = 8'h00;
    reg [7:0] run_b_q = 8'h00;
    reg [7:0] per_q = 8'h00;
    reg a_q = 1'b0;
    // Gate inputs have pull-downs, so an undriven pin reads as off
    wire drv_a = wave_out_a && !wave_out_a_oe_n;
    wire drv_b = wave_out_b && !wave_out_b_oe_n;
    // Pulse widths latch on the falling side, period on rising side of A
    always @(posedge ref_clk)
    begin
        a_q <= drv_a;
        run_a_q <= drv_a ? run_a_q + 8'h01 : 8'h00;
        run_b_q <= drv_b ? run_b_q + 8'h01 : 8'h00;
        if (!drv_a && run_a_q != 8'h00)
            on_a <= run_a_q;
        if (!drv_b && run_b_q != 8'h00)
            on_b <= run_b_q;
        per_q <= (drv_a && !a_q) ? 8'h01 : per_q + 8'h01;
        if (drv_a && !a_q)
            per_a <= per_q;
    end
endmodule // rps_stage_model

// *** dv/tb_top.sv ***
// Self-checking bench for the reduced power stage controller
`timescale 1ns/100ps
`include "rps_defs.vh"
module tb_top;
    reg ref_clk, rst, reg_wr, reg_rd, pll_en;
    reg pll_tick = 1'b0;
    reg [3:0] reg_addr, trig;
    reg [15:0] reg_wdata, v, cnt_seen;
    reg [7:0] ext_fuse_byte;
    wire [15:0] reg_rdata;
    wire [7:0] on_a, on_b, per_a;
    wire wave_out_a, wave_out_a_oe_n, wave_out_b, wave_out_b_oe_n;
    wire main_pin_pullup, alt_a_pullup, alt_b_pullup, controller_irq, adc_sync_pulse;
    integer mismatches, samples_checked, cyc, sync_cnt, s0, i;
    rps_top u_rps_top (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .ext_fuse_byte, .pll_tick, .main_trigger_pin(trig[0]),
        .comparator_out(trig[1]), .alt_trigger_pin_a(trig[2]),
        .alt_trigger_pin_b(trig[3]), .wave_out_a, .wave_out_a_oe_n, .wave_out_b,
        .wave_out_b_oe_n, .main_pin_pullup, .alt_a_pullup, .alt_b_pullup,
        .controller_irq, .adc_sync_pulse);
    rps_stage_model u_rps_stage_model (.ref_clk, .wave_out_a, .wave_out_a_oe_n,
        .wave_out_b, .wave_out_b_oe_n, .on_a, .on_b, .per_a);
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // PLL stand-in ticks every other cycle, halving the counter rate
    always @(posedge ref_clk)
    begin
        pll_tick <= pll_en & ~pll_tick;
        if (adc_sync_pulse === 1'b1)
            sync_cnt = sync_cnt + 1;
    end
    task stop_test;
    begin
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            $display("FAIL %0t got %h expected %h", $time, got, exp);
            mismatches = mismatches + 1;
        end
    end
    endtask
    task wr(input [3:0] a, input [15:0] d);
    begin
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    end
    endtask
    task rd(input [3:0] a);
    begin
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    end
    endtask
    task pins(input [15:0] exp);
    begin
        chk({9'h000, wave_out_a, wave_out_a_oe_n, wave_out_b, wave_out_b_oe_n,
            main_pin_pullup, alt_a_pullup, alt_b_pullup}, exp);
    end
    endtask
    // Reset with a given fuse byte, check the pins under reset, then step to the first released cycle
    task do_reset(input [7:0] f);
    begin
        @(posedge ref_clk);
        rst <= 1'b1;
        ext_fuse_byte <= f;
        repeat (4) @(posedge ref_clk);
        #1 pins({9'h000, f[4], f[5], f[4], f[5], ~f[3], ~f[3], 1'b0});
        @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
    end
    endtask
    // Cuts a hang short well past the expected run length
    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            stop_test;
        end
    end
    initial
    begin
        rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; pll_en = 1'b0;
        reg_addr = 4'h0; reg_wdata = 16'h0000; trig = 4'h0;
        ext_fuse_byte = `RPS_FUSE_DEFAULT;
        mismatches = 0; samples_checked = 0; cyc = 0; sync_cnt = 0;
        do_reset(`RPS_FUSE_DEFAULT);
        pins(16'h0028);
        rd(`RPS_ADDR_COUNT); chk(v, 16'h0000);
        rd(`RPS_ADDR_CAPTURE); chk(v, 16'h0000);
        wr(4'hf, 16'h0123); rd(4'hf); chk(v, 16'h0000);
        wr(`RPS_ADDR_SET_A, 16'h0abc); rd(`RPS_ADDR_SET_A); chk(v, 16'h0abc);
        do_reset(8'hc7);
        pins(16'h0000);
        repeat (5) @(posedge ref_clk);
        #1 pins(16'h0000);
        do_reset(8'hd7);
        pins(16'h0050);
        wr(`RPS_ADDR_SYNC_OUT, 16'h0000); @(posedge ref_clk);
        #1 pins(16'h0028);
        // Four-ramp: dead A 3, on A 3, dead B 2, on B 2, period 10
        wr(`RPS_ADDR_SET_A, 16'h0001); wr(`RPS_ADDR_RST_A, 16'h0003);
        wr(`RPS_ADDR_SET_B, 16'h0000); wr(`RPS_ADDR_RST_B, 16'h0002);
        wr(`RPS_ADDR_SYNC_OUT, 16'h0002); wr(`RPS_ADDR_CTRL, 16'h0001);
        repeat (40) @(posedge ref_clk);
        #1 s0 = sync_cnt;
        repeat (50) @(posedge ref_clk);
        #1 chk(sync_cnt - s0, 16'd5);
        chk({8'h00, on_a}, 16'd3); chk({8'h00, on_b}, 16'd2);
        chk({8'h00, per_a}, 16'd1 + 16'd2 + 16'd3 + 16'd0 + 16'd2 + 16'd2);
        wr(`RPS_ADDR_SYNC_OUT, 16'h0003); repeat (40) @(posedge ref_clk);
        chk({8'h00, on_a}, 16'd7);
        wr(`RPS_ADDR_SYNC_OUT, 16'h0002); wr(`RPS_ADDR_RST_A, 16'h0005);
        repeat (40) @(posedge ref_clk);
        chk({8'h00, on_a}, 16'd5); chk({8'h00, per_a}, 16'd12);
        pll_en <= 1'b1; wr(`RPS_ADDR_CTRL, 16'h0009); repeat (90) @(posedge ref_clk);
        chk({8'h00, per_a}, 16'd24); pll_en <= 1'b0;
        // Every running mode must keep producing sync pulses (at cycle end, or at the top in centered mode)
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(`RPS_ADDR_CTRL, {13'h0000, i[1:0], 1'b1});
            #1 s0 = sync_cnt;
            repeat (100) @(posedge ref_clk);
            chk({15'h0000, sync_cnt > s0}, 16'h0001);
        end
        // Each source in turn captures the counter and raises the request
        // PLL tick held off freezes the counter, so a capture must match the count read before
        wr(`RPS_ADDR_CTRL, 16'h0049);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(`RPS_ADDR_IN_SEL, {12'h001, 2'h0, i[1:0]}); wr(`RPS_ADDR_STATUS, 16'h0007);
            rd(`RPS_ADDR_COUNT); cnt_seen = v;
            @(posedge ref_clk); trig[i] <= 1'b1;
            repeat (4) @(posedge ref_clk); trig[i] <= 1'b0;
            rd(`RPS_ADDR_STATUS); chk(v & 16'h0006, 16'h0006);
            chk({15'h0000, controller_irq}, 16'h0001);
            rd(`RPS_ADDR_CAPTURE); chk(v, cnt_seen);
            wr(`RPS_ADDR_STATUS, 16'h0007); repeat (2) @(posedge ref_clk);
            #1 chk({15'h0000, controller_irq}, 16'h0000);
        end
        stop_test;
    end
endmodule // tb_top
